// ===== logic/eeprom_host_pkg.sv
// constants for the host controller of a byte-wide self-timed eeprom
// assumes a 20 MHz system clock
`default_nettype none
package eeprom_host_pkg;
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned CLK_NS        = 1000000000 / CLK_HZ;
	localparam int unsigned ADDR_W        = 11;
	localparam int unsigned COL_W         = 5;
	localparam int unsigned ROW_W         = 6;
	localparam int unsigned DATA_W        = 8;
	// pin timing in ns, T_DV_US in us and T_WC_MS in ms, least times round up
	localparam int unsigned T_AS_NS       = 10;
	localparam int unsigned T_WP_NS       = 150;
	localparam int unsigned T_AH_NS       = 70;
	localparam int unsigned T_DS_NS       = 50;
	localparam int unsigned T_OES_NS      = 10;
	localparam int unsigned T_OEH_NS      = 10;
	localparam int unsigned T_ACC_NS      = 350;
	localparam int unsigned T_DB_NS       = 200;
	localparam int unsigned T_NOISE_NS    = 20;
	localparam int unsigned T_DV_US       = 1;
	localparam int unsigned T_WC_MS       = 10;
	localparam int unsigned SETUP_CYC     =
		(T_AS_NS > T_OES_NS ? T_AS_NS : T_OES_NS) / CLK_NS + 1;
	localparam int unsigned WP_CYC        = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned HOLD_CYC      = (T_AH_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned ACC_CYC       = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BUSY_WAIT_CYC = (T_DB_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DV_CYC        = T_DV_US * 1000 / CLK_NS;
	localparam int unsigned WC_CYC        = T_WC_MS * 1000000 / CLK_NS;
	localparam int unsigned CNT_W         = 20;
	localparam logic [7:0]  SELF_ID       = 8'h5a; // arbitrary value
endpackage : eeprom_host_pkg
`default_nettype wire

// ===== logic/ready_sync.sv
// two-stage synchroniser for the open-drain ready/busy line
// assumes the input is asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module ready_sync (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic readyPin,
	output var  logic readySync
);
	logic stage1;
	logic next_stage1;
	logic next_readySync;

	always_comb begin
		next_stage1    = readyPin;
		next_readySync = stage1;
	end

	// both stages reset high: a pulled-up line reads ready
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stage1    <= 1'b1;
			readySync <= 1'b1;
		end else begin
			stage1    <= next_stage1;
			readySync <= next_readySync;
		end
	end
endmodule : ready_sync
`default_nettype wire

// ===== logic/eeprom_host.sv
// host controller driving a 2K x 8 self-timed eeprom over its parallel pins
// assumes an external pull-up on the ready/busy line; one request at a time
`timescale 1ns/1ps
`default_nettype none
module eeprom_host
	import eeprom_host_pkg::*;
#(
	parameter int unsigned WC_TIMEOUT = WC_CYC
) (
	input  wire logic                sys_clk,
	input  wire logic                resetn,
	input  wire logic                reqValid,
	input  wire logic                reqWrite,
	input  wire logic [ADDR_W-1:0]   reqAddr,
	input  wire logic [DATA_W-1:0]   reqData,
	output var  logic                reqReady,
	output var  logic                rspValid,
	output var  logic [DATA_W-1:0]   rspData,
	output var  logic                rspTimeout,
	output var  logic                chipSelectn,
	output var  logic                outDriven,
	output var  logic                writeStroben,
	output var  logic [COL_W-1:0]    column_addr,
	output var  logic [ROW_W-1:0]    row_addr,
	output var  logic [DATA_W-1:0]   dataOut,
	output var  logic                dataOe,
	input  wire logic [DATA_W-1:0]   dataIn,
	input  wire logic                readyPin
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_PULSE = 3'b010,
		ST_HOLD  = 3'b011,
		ST_DBUSY = 3'b100,
		ST_BUSY  = 3'b101,
		ST_READ  = 3'b110
	} state_e;

	state_e            state;
	state_e            next_state;
	logic [CNT_W-1:0]  count;
	logic [CNT_W-1:0]  next_count;
	logic [DATA_W-1:0] dataIn1;
	logic [DATA_W-1:0] dataIn2;
	logic              readySync;
	logic              next_reqReady;
	logic              next_rspValid;
	logic [DATA_W-1:0] next_rspData;
	logic              next_rspTimeout;
	logic              next_chipSelectn;
	logic              next_outDriven;
	logic              next_writeStroben;
	logic [COL_W-1:0]  next_column_addr;
	logic [ROW_W-1:0]  next_row_addr;
	logic [DATA_W-1:0] next_dataOut;
	logic              next_dataOe;

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	ready_sync readySyncInst (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.readyPin  (readyPin),
		.readySync (readySync)
	);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dataIn1 <= 8'h00;
			dataIn2 <= 8'h00;
		end else begin
			dataIn1 <= dataIn;
			dataIn2 <= dataIn1;
		end
	end

	// ----------------------------------------------------------------
	// pin sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state        = state;
		next_count        = count;
		next_reqReady     = 1'b0;
		next_rspValid     = 1'b0;
		next_rspData      = rspData;
		next_rspTimeout   = 1'b0;
		next_chipSelectn  = chipSelectn;
		next_outDriven    = outDriven;
		next_writeStroben = writeStroben;
		next_column_addr  = column_addr;
		next_row_addr     = row_addr;
		next_dataOut      = dataOut;
		next_dataOe       = dataOe;
		case (state)
			ST_IDLE: begin
				// standby, data lines floated
				next_chipSelectn  = 1'b1;
				next_writeStroben = 1'b1;
				next_outDriven    = 1'b1;
				next_dataOe       = 1'b0;
				// a low level means the device is still writing
				next_reqReady     = readySync && !(reqValid && reqReady);
				if (reqValid && reqReady && readySync) begin
					next_column_addr = reqAddr[COL_W-1:0];
					next_row_addr    = reqAddr[ADDR_W-1:COL_W];
					next_chipSelectn = 1'b0;
					next_count       = '0;
					if (reqWrite) begin
						// drive held high keeps read mode off
						next_outDriven = 1'b1;
						next_dataOut   = reqData;
						next_dataOe    = 1'b1;
						next_state     = ST_SETUP;
					end else begin
						next_outDriven = 1'b0;
						next_state     = ST_READ;
					end
				end
			end
			ST_SETUP: begin
				next_count = count + 1'b1;
				if (count >= CNT_W'(SETUP_CYC - 1)) begin
					// falling strobe is the later edge: address latched
					next_writeStroben = 1'b0;
					next_count        = '0;
					next_state        = ST_PULSE;
				end
			end
			ST_PULSE: begin
				// pulse kept far above the noise floor
				next_count = count + 1'b1;
				if (count >= CNT_W'(WP_CYC - 1)) begin
					// rising strobe comes first: data latched here
					next_writeStroben = 1'b1;
					next_count        = '0;
					next_state        = ST_HOLD;
				end
			end
			ST_HOLD: begin
				next_count = count + 1'b1;
				if (count >= CNT_W'(HOLD_CYC - 1)) begin
					next_chipSelectn = 1'b1;
					next_dataOe      = 1'b0;
					next_count       = '0;
					next_state       = ST_DBUSY;
				end
			end
			ST_DBUSY: begin
				// let busy assert and cross the synchroniser
				next_count = count + 1'b1;
				if (count >= CNT_W'(BUSY_WAIT_CYC + 2)) begin
					next_count = '0;
					next_state = ST_BUSY;
				end
			end
			ST_BUSY: begin
				// no erase step: device erases before writing
				next_count = count + 1'b1;
				if (readySync) begin
					next_rspValid = 1'b1;
					next_state    = ST_IDLE;
				end else if (count >= CNT_W'(WC_TIMEOUT)) begin
					next_rspValid   = 1'b1;
					next_rspTimeout = 1'b1;
					next_state      = ST_IDLE;
				end
			end
			ST_READ: begin
				next_count = count + 1'b1;
				if (count >= CNT_W'(ACC_CYC + 1)) begin
					next_rspData     = dataIn2;
					next_rspValid    = 1'b1;
					next_chipSelectn = 1'b1;
					next_outDriven   = 1'b1;
					next_state       = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state        <= ST_IDLE;
			count        <= '0;
			reqReady     <= 1'b0;
			rspValid     <= 1'b0;
			rspData      <= 8'h00;
			rspTimeout   <= 1'b0;
			chipSelectn  <= 1'b1;
			outDriven    <= 1'b1;
			writeStroben <= 1'b1;
			column_addr  <= 5'h00;
			row_addr     <= 6'h00;
			dataOut      <= 8'h00;
			dataOe       <= 1'b0;
		end else begin
			state        <= next_state;
			count        <= next_count;
			reqReady     <= next_reqReady;
			rspValid     <= next_rspValid;
			rspData      <= next_rspData;
			rspTimeout   <= next_rspTimeout;
			chipSelectn  <= next_chipSelectn;
			outDriven    <= next_outDriven;
			writeStroben <= next_writeStroben;
			column_addr  <= next_column_addr;
			row_addr     <= next_row_addr;
			dataOut      <= next_dataOut;
			dataOe       <= next_dataOe;
		end
	end
endmodule : eeprom_host
`default_nettype wire

// ===== testbench/eeprom_host_props.sv
// pin-level checks on the eeprom host
// bound to every eeprom_host instance
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_props
	import eeprom_host_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              resetn,
	input wire logic              reqReady,
	input wire logic              rspValid,
	input wire logic              rspTimeout,
	input wire logic              chipSelectn,
	input wire logic              outDriven,
	input wire logic              writeStroben,
	input wire logic [COL_W-1:0]  column_addr,
	input wire logic [ROW_W-1:0]  row_addr,
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic              dataOe,
	input wire logic              readyPin
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_write_mode: assert property (
		!writeStroben |-> !chipSelectn && outDriven)
		else $error("strobe low outside write mode");
	a_strobe_width: assert property (
		$fell(writeStroben) |-> !writeStroben [*3])
		else $error("strobe pulse too short");
	a_addr_hold: assert property (
		!chipSelectn && !$past(chipSelectn)
		|-> $stable({row_addr, column_addr}))
		else $error("address moved while selected");
	a_data_valid: assert property (
		!writeStroben |-> dataOe && $stable(dataOut))
		else $error("data not held during strobe");
	a_read_mode: assert property (
		!outDriven |-> !chipSelectn && writeStroben && !dataOe)
		else $error("bad read mode pins");
	a_busy_block: assert property (
		!readyPin [*4] |=> !reqReady)
		else $error("ready offered while busy");
	a_busy_idle: assert property (
		!readyPin [*4] |-> chipSelectn)
		else $error("device selected while busy");
	a_done_after: assert property (
		$rose(readyPin) |-> ##[1:6] rspValid)
		else $error("no completion after ready");
	a_timeout_pair: assert property (
		rspTimeout |-> rspValid)
		else $error("timeout without response");
	c_write: cover property ($fell(writeStroben));
	c_read: cover property ($fell(outDriven));
	c_timeout: cover property (rspTimeout);
endmodule : eeprom_host_props
bind eeprom_host eeprom_host_props props_u (.sys_clk(sys_clk),
	.resetn(resetn), .reqReady(reqReady), .rspValid(rspValid),
	.rspTimeout(rspTimeout), .chipSelectn(chipSelectn),
	.outDriven(outDriven), .writeStroben(writeStroben),
	.column_addr(column_addr), .row_addr(row_addr),
	.dataOut(dataOut), .dataOe(dataOe), .readyPin(readyPin));
`default_nettype wire

// ===== testbench/eeprom_model.sv
// behavioural 2K x 8 self-timed eeprom
// strobe-controlled writes; stall stretches the busy time
`timescale 1ns/1ps
`default_nettype none
module eeprom_model #(
	parameter int BUSY_NS = 1000
) (
	input  wire logic       chipSelectn,
	input  wire logic       outDriven,
	input  wire logic       writeStroben,
	input  wire logic [4:0] column_addr,
	input  wire logic [5:0] row_addr,
	input  wire logic [7:0] dataOut,
	input  wire logic       dataOe,
	input  wire logic       stall,
	output var  logic [7:0] dataIn,
	output var  logic       readyPin
);
	logic [7:0]  mem [2048];
	logic [10:0] addr;
	logic        busy = 1'b0;
	logic        armed = 1'b0;
	logic [7:0]  last = 8'h00;
	realtime     tFall;
	wire         rd = !chipSelectn && !outDriven && writeStroben;
	always @(negedge writeStroben) begin
		armed = 1'b1;
		tFall = $realtime;
		addr = {row_addr, column_addr};
	end
	// select falling after the strobe latches the address instead
	always @(negedge chipSelectn) begin
		if (!writeStroben) addr = {row_addr, column_addr};
	end
	always @(posedge writeStroben) begin
		if (armed && !chipSelectn && outDriven && !busy
			&& $realtime - tFall >= 20.0) begin
			// an undriven bus stores junk, here the inverse of the data
			mem[addr] = dataOe ? dataOut : ~dataOut;
			busy = 1'b1;
			#(stall ? 20 * BUSY_NS : BUSY_NS);
			busy = 1'b0;
		end
	end
	always @(*) begin
		if (rd) last = mem[{row_addr, column_addr}];
	end
	assign readyPin = busy ? 1'b0 : 1'b1;
	// a read while the write runs gives no valid data
	assign dataIn = (rd && !busy) ? last : ~last;
endmodule : eeprom_model
`default_nettype wire

// ===== testbench/tb_eeprom_host.sv
// self-checking bench for the eeprom host
// drives the user side, model on the pins
`timescale 1ns/1ps
`default_nettype none
module tb_eeprom_host;
	import eeprom_host_pkg::*;
	logic        sys_clk, resetn, reqValid, reqWrite, stall;
	logic [10:0] reqAddr;
	logic [7:0]  reqData, rspData, dataOut, dataIn;
	logic        reqReady, rspValid, rspTimeout, readyPin;
	logic        chipSelectn, outDriven, writeStroben, dataOe;
	logic [4:0]  column_addr;
	logic [5:0]  row_addr;
	int          failures, num_checks;
	eeprom_host #(.WC_TIMEOUT(200)) dut_u (.sys_clk(sys_clk),
		.resetn(resetn), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
		.rspValid(rspValid), .rspData(rspData),
		.rspTimeout(rspTimeout), .chipSelectn(chipSelectn),
		.outDriven(outDriven), .writeStroben(writeStroben),
		.column_addr(column_addr), .row_addr(row_addr),
		.dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
		.readyPin(readyPin));
	eeprom_model model_u (.chipSelectn(chipSelectn),
		.outDriven(outDriven), .writeStroben(writeStroben),
		.column_addr(column_addr), .row_addr(row_addr),
		.dataOut(dataOut), .dataOe(dataOe), .stall(stall),
		.dataIn(dataIn),
		.readyPin(readyPin));
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic results;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	task automatic access(input logic w, input logic [10:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic to);
		int n;
		@(posedge sys_clk);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqData <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (reqReady !== 1'b1 && n < 2000);
		reqValid <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rspValid !== 1'b1 && n < 2000);
		q = rspData;
		to = rspTimeout;
		check("response", {7'h00, n < 2000}, 8'h01);
	endtask : access
	task automatic t_write_read;
		logic [10:0] a [4] = '{11'h000, 11'h01f, 11'h020, 11'h7ff};
		logic [7:0]  q;
		logic        to;
		foreach (a[i]) begin
			access(1'b1, a[i], a[i][7:0] ^ 8'h96, q, to);
			check("write timeout", {7'h00, to}, 8'h00);
		end
		foreach (a[i]) begin
			access(1'b0, a[i], 8'h00, q, to);
			check("readback", q, a[i][7:0] ^ 8'h96);
		end
	endtask : t_write_read
	task automatic t_overwrite;
		logic [7:0] q;
		logic       to;
		access(1'b1, 11'h123, 8'h3c, q, to);
		access(1'b1, 11'h123, 8'hc3, q, to);
		access(1'b0, 11'h123, 8'h00, q, to);
		check("overwrite", q, 8'hc3);
	endtask : t_overwrite
	task automatic t_timeout;
		logic [7:0] q;
		logic       to;
		stall <= 1'b1;
		access(1'b1, 11'h055, 8'h11, q, to);
		check("busy level", {7'h00, readyPin}, 8'h00);
		check("timeout", {7'h00, to}, 8'h01);
		resetn <= 1'b0;
		stall <= 1'b0;
		wait (readyPin === 1'b1);
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		access(1'b0, 11'h7ff, 8'h00, q, to);
		check("after reset", q, 8'h69);
	endtask : t_timeout
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		#2000000;
		failures++;
		results();
	end
	initial begin
		resetn = 1'b0;
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqAddr = 11'h000;
		reqData = 8'h00;
		stall = 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		t_write_read();
		t_overwrite();
		t_timeout();
		results();
	end
endmodule : tb_eeprom_host
`default_nettype wire
